// *** logic/mpeb_port_bus.sv ***
`timescale 1ns/1ns
`include "mpeb_regs.svh"
// Overview of operation
// RQ1 - Read strobe pulses on every bus read
// RQ2 - Write strobe pulses on every bus write
// RQ3 - Exactly one address latch pulse per cycle
// RQ4 - Address held valid across latch falling edge
// RQ5 - Fetch strobe only for external program fetches
// RQ6 - Force input sends every fetch outside
// RQ7 - 4096 space, above 1023 fetched externally
// RQ8 - General port outputs latched until rewritten
// RQ9 - General port inputs sampled only when read
// RQ10 - Weak pull-up, boost on one, sink zero
// RQ11 - Reset leaves general ports weakly high
// RQ12 - Bus is bidirectional with strobes otherwise
// RQ13 - Bus also latched output or plain input
// RQ14 - Latched output pulses write, input pulses read
// RQ15 - Data moves use read or write strobe
// RQ16 - Bus floats when no transfer in progress
// RQ17 - Three ports plus three test inputs
// RQ18 - External data space of 256 words
// RQ19 - Upper fetch address on port two nibble
// RQ20 - Low fetch address on bus, byte returned
// RQ21 - Reset floats bus, ports to input
// RQ22 - Machine cycle is five states
// RQ23 - Address, latch drop, float, then strobe
module mpeb_port_bus (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire mpeb_pkg::mpeb_op_e cmdOp,
    input wire logic [11:0] cmdAddr,
    input wire logic [7:0] cmdData,
    output logic rspValid,
    output logic [7:0] rspData,
    output logic [9:0] romAddr,
    input wire logic [7:0] romData,
    input wire logic externalFetchForce,
    input wire logic [2:0] testIn,
    input wire logic [7:0] busIn,
    output logic [7:0] busOut,
    output logic busOe,
    output logic aleOut,
    output logic rdStrobeN,
    output logic wrStrobeN,
    output logic programFetchStrobeN,
    input wire logic [7:0] p1In,
    output logic [7:0] p1Out,
    output logic [7:0] p1Oe,
    input wire logic [7:0] p2In,
    output logic [7:0] p2Out,
    output logic [7:0] p2Oe
);
    import mpeb_pkg::*;

    // Does an operation need the bus lines
    function automatic logic takesBus(mpeb_op_e op, logic [11:0] a, logic ea);
        logic ext;
        ext = (op == OP_FETCH) && (ea || a >= `MPEB_INT_ROM_SIZE);
        takesBus = ext || op == OP_XDATA_RD || op == OP_XDATA_WR || op == OP_BUS_IN;
    endfunction

    logic rstMeta_q;
    logic rstSync_q;
    mpeb_phase_e phase_q;
    mpeb_phase_e phase_d;
    mpeb_op_e op_q;
    logic [11:0] addr_q;
    logic [7:0] data_q;
    logic ea_q;
    logic [7:0] busLatch_q;
    logic latchedDrive_q;
    logic [7:0] busOut_q;
    logic busOe_q;
    logic ale_q;
    logic rd_q;
    logic wr_q;
    logic program_fetch_strobe_n_q;
    logic rspValid_q;
    logic [7:0] rspData_q;
    logic [7:0] portLatch_q [2];
    logic [7:0] portBoost_q [2];

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    // Decode of the operation in flight
    // RQ6 RQ7 forced or high fetch
    wire extFetch = op_q == OP_FETCH && (ea_q || addr_q >= `MPEB_INT_ROM_SIZE);
    wire isXrd = op_q == OP_XDATA_RD;
    wire isXwr = op_q == OP_XDATA_WR;
    wire isBusIn = op_q == OP_BUS_IN;
    wire isBusOut = op_q == OP_BUS_OUT;
    wire usesAddr = extFetch || isXrd || isXwr;
    wire addrPh = phase_q == PH_ADDR || phase_q == PH_HOLD;
    wire xferPh = phase_q == PH_XFER1 || phase_q == PH_XFER2;
    wire takeCmd = ce && phase_q == PH_DONE;
    wire cmdOwnsBus = cmdValid && takesBus(cmdOp, cmdAddr, externalFetchForce);
    wire endOfCycle = phase_q == PH_DONE;

    // Commands only at the cycle boundary; ready is a handshake term
    assign cmdReady = rstSync_q && takeCmd;

    // RQ22 five states
    // Fixed walk keeps every cycle the same length
    always_comb begin
        unique case (phase_q)
            PH_ADDR: phase_d = PH_HOLD;
            PH_HOLD: phase_d = PH_XFER1;
            PH_XFER1: phase_d = PH_XFER2;
            PH_XFER2: phase_d = PH_DONE;
            default: phase_d = PH_ADDR;
        endcase
    end

    // Cycle state and captured command
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            phase_q <= PH_DONE;
            op_q <= OP_NOP;
            addr_q <= 12'h000;
            data_q <= 8'h00;
            ea_q <= 1'b0;
        end else if (ce) begin
            phase_q <= phase_d;
            if (takeCmd) begin
                op_q <= cmdValid ? cmdOp : OP_NOP;
                addr_q <= cmdAddr;
                data_q <= cmdData;
                ea_q <= externalFetchForce;
            end
        end
    end

    // Pin values one state ahead of the flops
    // RQ23 address, float, strobe
    // RQ4 RQ12 RQ16 drive while transferring or while the latched output holds the bus
    // RQ18 eight-bit data address
    wire busOeD = (addrPh && usesAddr) || (xferPh && isXwr) || isBusOut || latchedDrive_q;
    wire [7:0] busOutD = (addrPh && usesAddr) ? addr_q[7:0] :
        (isXwr || isBusOut) ? data_q : busLatch_q;
    // RQ3 one latch pulse
    wire aleD = phase_q == PH_ADDR;
    // RQ1 read strobe
    // RQ15 data move strobes
    wire rdD = !(xferPh && (isBusIn || isXrd));
    // RQ2 write strobe
    // RQ14 latched output write
    wire wrD = !(xferPh && (isBusOut || isXwr));
    // RQ5 external fetch only
    wire psenD = !(xferPh && extFetch);

    // Registered pins avoid decode glitches on strobes
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            busOut_q <= 8'h00;
            busOe_q <= 1'b0;
            ale_q <= 1'b0;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            program_fetch_strobe_n_q <= 1'b1;
        end else if (ce) begin
            busOut_q <= busOutD;
            busOe_q <= busOeD;
            ale_q <= aleD;
            rd_q <= rdD;
            wr_q <= wrD;
            program_fetch_strobe_n_q <= psenD;
        end
    end

    // RQ13 static latched output
    // Latch stays driven until something else needs the lines
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            busLatch_q <= 8'h00;
            latchedDrive_q <= 1'b0;
        end else if (ce) begin
            if (phase_q == PH_XFER1 && isBusOut) begin
                busLatch_q <= data_q;
                latchedDrive_q <= 1'b1;
            end else if (takeCmd && cmdOwnsBus) begin
                latchedDrive_q <= 1'b0;
            end
        end
    end

    // RQ9 sample at read
    // RQ20 fetched byte
    // RQ17 test inputs
    wire [7:0] captureD = (extFetch || isXrd || isBusIn) ? busIn :
        (op_q == OP_FETCH) ? romData :
        (op_q == OP_P1_RD) ? p1In :
        (op_q == OP_P2_RD) ? p2In :
        (op_q == OP_TEST_RD) ? {5'h00, testIn} : 8'h00;

    // Capture while the strobe is still low; answer on the same edge that raises it
    always_ff @(posedge clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            rspValid_q <= 1'b0;
            rspData_q <= 8'h00;
        end else if (ce) begin
            rspValid_q <= endOfCycle && op_q != OP_NOP;
            if (endOfCycle) begin
                rspData_q <= captureD;
            end
        end
    end

    // RQ8 port latches
    // RQ11 reset high
    genvar g;
    for (g = 0; g < 2; g++) begin : genPort
        wire portWr = phase_q == PH_XFER1 && op_q == (g == 0 ? OP_P1_WR : OP_P2_WR);
        always_ff @(posedge clk or negedge rstSync_q) begin
            if (!rstSync_q) begin
                portLatch_q[g] <= `MPEB_PORT_RESET;
                portBoost_q[g] <= 8'h00;
            end else if (ce) begin
                portLatch_q[g] <= portWr ? data_q : portLatch_q[g];
                portBoost_q[g] <= portWr ? data_q : 8'h00;
            end
        end
    end

    // RQ10 quasi-bidirectional drive
    // Ones released to the weak pull-up after one boost state
    assign p1Out = portLatch_q[0];
    assign p1Oe = ~portLatch_q[0] | portBoost_q[0];
    // RQ19 upper fetch nibble
    assign p2Out = {portLatch_q[1][7:4], extFetch ? addr_q[11:8] : portLatch_q[1][3:0]};
    assign p2Oe = {~portLatch_q[1][7:4] | portBoost_q[1][7:4],
        extFetch ? 4'hf : ~portLatch_q[1][3:0] | portBoost_q[1][3:0]};

    // Internal ROM takes the low ten bits
    assign romAddr = addr_q[9:0];
    assign busOut = busOut_q;
    // RQ21 bus floats at reset
    assign busOe = busOe_q;
    assign aleOut = ale_q;
    assign rdStrobeN = rd_q;
    assign wrStrobeN = wr_q;
    assign programFetchStrobeN = program_fetch_strobe_n_q;
    assign rspValid = rspValid_q;
    assign rspData = rspData_q;

    // Checks stay quiet in reset and while frozen
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_q || !ce);

    chk_ale_once_cycle: assert property ( // RQ3
        $rose(aleOut) |=> !aleOut [*4] ##1 aleOut)
        else $error("address latch pulse not once per cycle");

    chk_addr_hold_fall: assert property ( // RQ4
        $fell(aleOut) && $past(busOe) |-> busOe && $stable(busOut))
        else $error("address not held across latch edge");

    chk_fetch_strobe_ext: assert property ( // RQ5
        !programFetchStrobeN |-> extFetch && !busOe)
        else $error("fetch strobe outside external fetch");

    chk_force_ext_fetch: assert property ( // RQ6
        phase_q == PH_XFER1 && op_q == OP_FETCH && ea_q |=> !programFetchStrobeN [*2])
        else $error("forced fetch not external");

    chk_rom_boundary_fetch: assert property ( // RQ7
        phase_q == PH_XFER1 && op_q == OP_FETCH |=>
        programFetchStrobeN == !(ea_q || addr_q >= `MPEB_INT_ROM_SIZE))
        else $error("fetch placed on wrong side of rom boundary");

    chk_port_latch_hold: assert property ( // RQ8
        !(phase_q == PH_XFER1 && op_q == OP_P1_WR) |=> $stable(p1Out))
        else $error("port latch changed without write");

    chk_boost_one_state: assert property ( // RQ10
        $rose(p1Oe[0]) && p1Out[0] |=> !p1Oe[0])
        else $error("strong pull-up held too long");

    chk_ports_reset_high: assert property ( // RQ11
        $rose(rstSync_q) |-> p1Out == `MPEB_PORT_RESET && p1Oe == 8'h00)
        else $error("port not weakly high after reset");

    chk_read_floats_bus: assert property ( // RQ1
        !rdStrobeN |-> !busOe && wrStrobeN)
        else $error("bus driven during read strobe");

    chk_write_drives_bus: assert property ( // RQ2
        $fell(wrStrobeN) |-> busOe ##1 (!wrStrobeN && busOe) ##1 wrStrobeN)
        else $error("write strobe without driven bus");

    chk_bus_idle_float: assert property ( // RQ16
        phase_q == PH_XFER1 && op_q == OP_NOP && !latchedDrive_q |=> !busOe)
        else $error("bus driven while idle");

    chk_p2_fetch_nibble: assert property ( // RQ19
        !programFetchStrobeN |-> p2Oe[3:0] == 4'hf && p2Out[3:0] == addr_q[11:8])
        else $error("upper fetch address missing on port two");

    chk_p2_latch_hold: assert property ( // RQ8
        !(phase_q == PH_XFER1 && op_q == OP_P2_WR) |=> $stable(p2Out[7:4]))
        else $error("port two latch changed without write");

    chk_fetch_addr_bus: assert property ( // RQ20
        aleOut && extFetch |-> busOe && busOut == addr_q[7:0])
        else $error("low fetch address missing on bus");

    chk_xdata_addr_bus: assert property ( // RQ18
        aleOut && (isXrd || isXwr) |-> busOe && busOut == addr_q[7:0])
        else $error("data address missing on bus");

    chk_strobe_after_latch: assert property ( // RQ23
        !rdStrobeN || !programFetchStrobeN |-> !aleOut && !busOe)
        else $error("read strobe before address phase ended");

    chk_write_data_bus: assert property ( // RQ14
        !wrStrobeN |-> busOe && busOut == data_q)
        else $error("write strobe without its data on bus");

    chk_reset_pins_idle: assert property ( // RQ21
        $rose(rstSync_q) |-> !busOe && rdStrobeN && wrStrobeN && programFetchStrobeN)
        else $error("bus or strobes active after reset");

    // Own disable term so that the frozen cycles themselves are watched
    chk_ce_freeze_state: assert property (@(posedge clk) disable iff (!rstSync_q) // RQ22
        !ce |=> $stable(phase_q) && $stable(aleOut) && $stable(p1Out) && $stable(rspValid))
        else $error("state moved while clock enable low");

    // Main scenarios seen at least once
    cov_ext_fetch: cover property ($fell(programFetchStrobeN));
    cov_xdata_read: cover property (isXrd && $fell(rdStrobeN));
    cov_xdata_write: cover property (isXwr && $fell(wrStrobeN));
    cov_latched_out: cover property ($rose(latchedDrive_q));
    cov_forced_fetch: cover property (ea_q && $fell(programFetchStrobeN));
endmodule

// *** pkg/mpeb_pkg.sv ***
package mpeb_pkg;

    // Operations handed in by the core
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_FETCH = 4'h1,
        OP_BUS_OUT = 4'h2,
        OP_BUS_IN = 4'h3,
        OP_XDATA_RD = 4'h4,
        OP_XDATA_WR = 4'h5,
        OP_P1_WR = 4'h6,
        OP_P2_WR = 4'h7,
        OP_P1_RD = 4'h8,
        OP_P2_RD = 4'h9,
        OP_TEST_RD = 4'ha
    } mpeb_op_e;

    // States of one machine cycle
    typedef enum logic [4:0] {
        PH_ADDR = 5'b00001,
        PH_HOLD = 5'b00010,
        PH_XFER1 = 5'b00100,
        PH_XFER2 = 5'b01000,
        PH_DONE = 5'b10000
    } mpeb_phase_e;

endpackage

// *** pkg/mpeb_regs.svh ***
`ifndef MPEB_REGS_SVH
`define MPEB_REGS_SVH

// Program space and internal ROM window
`define MPEB_PC_WIDTH 12
`define MPEB_PROG_SPACE 4096
`define MPEB_INT_ROM_SIZE 12'h400
`define MPEB_ROM_WIDTH 10

// Machine cycle length in states
`define MPEB_STATES_PER_CYCLE 5

// Port widths and reset value
`define MPEB_PORT_WIDTH 8
`define MPEB_PORT_RESET 8'hff
`define MPEB_TEST_WIDTH 3

`endif

// *** verification/mpeb_ext_mem.sv ***
`timescale 1ns/1ns
// Memory and I/O device on the far side of the bus port
module mpeb_ext_mem #(
    parameter logic [7:0] IO_VAL = 8'h69
) (
    input wire logic clk,
    input wire logic aleOut,
    input wire logic busOe,
    input wire logic [7:0] busLevel,
    input wire logic [3:0] p2Nib,
    input wire logic rdStrobeN,
    input wire logic wrStrobeN,
    input wire logic programFetchStrobeN,
    output logic [7:0] memDrv
);
    logic [7:0] mem [0:255];
    logic known [0:255];
    logic [7:0] lat;
    logic [3:0] nib;
    logic addrOk = 1'b0;
    logic [7:0] last = 8'h00;
    logic [7:0] val;
    logic active;
    always @(negedge aleOut) begin
        lat = busLevel;
        nib = p2Nib;
        addrOk = busOe;
    end
    // Unwritten places answer with a pattern of the full address
    assign val = !addrOk ? IO_VAL : (known[lat] === 1'b1) ? mem[lat] : lat ^ {nib, nib};
    assign active = !rdStrobeN || !programFetchStrobeN;
    // Released bus shows the inverse, never a stale byte
    assign memDrv = active ? val : ~last;
    always @(posedge clk) begin
        if (active) begin
            last <= val;
        end
        if (!wrStrobeN && addrOk) begin
            mem[lat] <= busLevel;
            known[lat] <= 1'b1;
        end
    end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
    import mpeb_pkg::*;
    typedef struct {mpeb_op_e op; logic [11:0] addr; logic [7:0] data; logic ext;
        logic [7:0] exp; logic [1:0] stb;} mpeb_row_s;
    logic clk, rst_n, ce, cmdValid, cmdReady, rspValid, externalFetchForce, busOe, aleOut;
    logic rdStrobeN, wrStrobeN, programFetchStrobeN, pF, pR, pW, pA;
    logic [7:0] cmdData, rspData, romData, busIn, busOut, memDrv, p1In, p1Out, p1Oe;
    logic [7:0] p2In, p2Out, p2Oe, p1Ext, p2Ext, nFetch, nRd, nWr, nAle;
    logic [9:0] romAddr;
    logic [11:0] cmdAddr;
    logic [2:0] testIn;
    mpeb_op_e cmdOp;
    int err_count = 0, n_compared = 0, cyc = 0;
    mpeb_row_s rows [11] = '{
        '{OP_P1_WR, 12'h000, 8'h3c, 1'b0, 8'h00, 2'd0}, '{OP_P1_RD, 12'h000, 8'h00, 1'b0, 8'h3c, 2'd0},
        '{OP_XDATA_WR, 12'h021, 8'h77, 1'b0, 8'h00, 2'd3}, '{OP_XDATA_RD, 12'h021, 8'h00, 1'b0, 8'h77, 2'd2},
        '{OP_FETCH, 12'h7a5, 8'h00, 1'b0, 8'hd2, 2'd1}, '{OP_FETCH, 12'h3ff, 8'h00, 1'b0, 8'h3c, 2'd0},
        '{OP_FETCH, 12'h3ff, 8'h00, 1'b1, 8'hcc, 2'd1}, '{OP_FETCH, 12'h400, 8'h00, 1'b0, 8'h44, 2'd1},
        '{OP_TEST_RD, 12'h000, 8'h00, 1'b0, 8'h05, 2'd0}, '{OP_P2_WR, 12'h000, 8'ha0, 1'b0, 8'h00, 2'd0},
        '{OP_P2_RD, 12'h000, 8'h00, 1'b0, 8'ha0, 2'd0}};
    // Bus wire and quasi-bidirectional pins with pull-ups
    assign busIn = busOe ? busOut : memDrv;
    assign romData = romAddr[7:0] ^ 8'hc3;
    assign p1In = p1Ext & ((p1Out & p1Oe) | ~p1Oe);
    assign p2In = p2Ext & ((p2Out & p2Oe) | ~p2Oe);
    mpeb_port_bus u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdAddr(cmdAddr), .cmdData(cmdData),
        .rspValid(rspValid), .rspData(rspData), .romAddr(romAddr), .romData(romData),
        .externalFetchForce(externalFetchForce), .testIn(testIn), .busIn(busIn),
        .busOut(busOut), .busOe(busOe), .aleOut(aleOut), .rdStrobeN(rdStrobeN),
        .wrStrobeN(wrStrobeN), .programFetchStrobeN(programFetchStrobeN), .p1In(p1In),
        .p1Out(p1Out), .p1Oe(p1Oe), .p2In(p2In), .p2Out(p2Out), .p2Oe(p2Oe));
    mpeb_ext_mem u_mem (.clk(clk), .aleOut(aleOut), .busOe(busOe), .busLevel(busIn),
        .p2Nib(p2Out[3:0]), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN),
        .programFetchStrobeN(programFetchStrobeN), .memDrv(memDrv));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h got %h", name, exp, got);
        end
    endtask
    task automatic do_op(input mpeb_row_s r);
        int i;
        cmdOp = r.op;
        cmdAddr = r.addr;
        cmdData = r.data;
        externalFetchForce = r.ext;
        cmdValid = 1'b1;
        {nFetch, nRd, nWr} = '0;
        for (i = 0; i < 10 && cmdReady !== 1'b1; i++) begin
            @(posedge clk) #1;
        end
        @(posedge clk) #1;
        cmdValid = 1'b0;
        for (i = 0; i < 10 && rspValid !== 1'b1; i++) begin
            @(posedge clk) #1;
        end
        chk("rspValid", 8'h01, {7'h0, rspValid});
    endtask
    task automatic reset_check();
        chk("p1Out", 8'hff, p1Out);
        chk("p2Oe", 8'h00, p2Oe);
        chk("busOe", 8'h00, {7'h0, busOe});
        chk("p1Oe", 8'h00, p1Oe);
        chk("strobes", 8'h07, {5'h0, rdStrobeN, wrStrobeN, programFetchStrobeN});
    endtask
    // Hang limit, far above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            end_of_test();
        end
    end
    // Strobe and latch pulse counters
    always @(posedge clk) begin
        if (pF && !programFetchStrobeN) nFetch++;
        if (pR && !rdStrobeN) nRd++;
        if (pW && !wrStrobeN) nWr++;
        if (!pA && aleOut) nAle++;
        {pF, pR, pW, pA} = {programFetchStrobeN, rdStrobeN, wrStrobeN, aleOut};
    end
    initial begin
        {rst_n, cmdValid, externalFetchForce, cmdAddr, cmdData} = '0;
        cmdOp = OP_NOP;
        ce = 1'b1;
        {p1Ext, p2Ext, testIn} = {8'hff, 8'hff, 3'b101};
        repeat (6) @(posedge clk);
        #1 reset_check();
        rst_n = 1'b1;
        $display("test reset done");
        foreach (rows[k]) begin
            do_op(rows[k]);
            chk("rspData", rows[k].exp, rspData);
            chk("fetchStrobes", {7'h0, rows[k].stb == 2'd1}, nFetch);
            chk("rdStrobes", {7'h0, rows[k].stb == 2'd2}, nRd);
            chk("wrStrobes", {7'h0, rows[k].stb == 2'd3}, nWr);
            $display("test row %0d done", k);
        end
        chk("p1Held", 8'h3c, p1Out);
        chk("p2Out", 8'ha0, p2Out);
        chk("p2Oe", 8'h5f, p2Oe);
        do_op('{OP_BUS_OUT, 12'h000, 8'h96, 1'b0, 8'h00, 2'd0});
        chk("wrStrobes", 8'h01, nWr);
        repeat (12) @(posedge clk);
        #1 chk("busOut", 8'h96, busOut);
        chk("busOe", 8'h01, {7'h0, busOe});
        do_op('{OP_BUS_IN, 12'h000, 8'h00, 1'b0, 8'h00, 2'd0});
        chk("busIn", 8'h69, rspData);
        chk("rdStrobes", 8'h01, nRd);
        chk("busFloat", 8'h00, {7'h0, busOe});
        $display("test bus port done");
        p1Ext = 8'h00;
        do_op('{OP_P1_RD, 12'h000, 8'h00, 1'b0, 8'h00, 2'd0});
        chk("p1Pins", 8'h00, rspData);
        nAle = 8'h00;
        repeat (50) @(posedge clk);
        #1 chk("aleCount", 8'h0a, nAle);
        $display("test latch pulse done");
        // One edge with enable low first, so a pulse just launched is not counted
        ce = 1'b0;
        @(posedge clk) #1;
        nAle = 8'h00;
        repeat (20) @(posedge clk);
        #1 chk("aleFrozen", 8'h00, nAle);
        chk("readyFrozen", 8'h00, {7'h0, cmdReady});
        ce = 1'b1;
        $display("test clock enable done");
        rst_n = 1'b0;
        #1 reset_check();
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        do_op('{OP_P1_RD, 12'h000, 8'h00, 1'b0, 8'h00, 2'd0});
        chk("p1After", 8'h00, rspData);
        do_op('{OP_P1_WR, 12'h000, 8'ha5, 1'b0, 8'h00, 2'd0});
        chk("p1Out", 8'ha5, p1Out);
        chk("p1Oe", 8'h5a, p1Oe);
        $display("test second reset done");
        end_of_test();
    end
endmodule
